// ==== rtl/iafs_consts.vh ====
// constants for the abort-flag and data-setup block
`ifndef IAFS_CONSTS_VH
`define IAFS_CONSTS_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define IAFS_ADDR_ABORT 32'h50001380
`define IAFS_ADDR_SETUP 32'h50001394
`define IAFS_ADDR_CTRL 32'h500013a0
`define IAFS_ADDR_CLEAR 32'h500013a4

// ----------------------------------------
// reset values and field layout
// ----------------------------------------
`define IAFS_SETUP_RESET 8'h64
`define IAFS_SETUP_MIN 8'h02
`define IAFS_CTRL_ENABLE 0
`define IAFS_CTRL_WIDE 1
`define IAFS_CTRL_MASTER 2
`define IAFS_FLAG_SHORT 0
`define IAFS_FLAG_WIDE1 1
`define IAFS_FLAG_WIDE2 2
`define IAFS_FLAG_DATA 3
`define IAFS_FLAG_GCALL 4
`define IAFS_NUM_FLAGS 5

// ----------------------------------------
// bus protocol values
// ----------------------------------------
`define IAFS_GCALL_BYTE 8'h00
`define IAFS_ACK_SLOT 4'h8
`define IAFS_LAST_BIT 4'h7
`define IAFS_BYTE_FIRST 2'h0
`define IAFS_BYTE_SECOND 2'h1
`define IAFS_BYTE_LATER 2'h2

`endif

// ==== rtl/iafs_delay_timer.v ====
// down-counter that times the programmed data setup delay
`default_nettype none

module iafs_delay_timer (
    input wire clock, // block clock
    input wire rst_n, // async reset, active low
    input wire start, // pulse: begin a delay
    input wire [7:0] load_value, // delay length in clock periods
    output reg busy, // high while delay runs
    output reg done // pulse: delay over
);

reg [7:0] count;

// ----------------------------------------
// delay counter
// ----------------------------------------
// a value of zero is treated as one period
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        count <= 8'h00;
        busy <= 1'b0;
        done <= 1'b0;
    end
    else
    begin
        done <= 1'b0;
        if (start)
        begin
            count <= load_value;
            busy <= 1'b1;
        end
        else if (busy)
        begin
            if (count <= 8'h01)
            begin
                busy <= 1'b0;
                done <= 1'b1;
            end
            else
                count <= count - 8'h01;
        end
    end
end

endmodule
`default_nettype wire

// ==== rtl/iafs_core.v ====
// abort cause flags and slave-transmitter data setup delay
// Functional notes
// - master general call left unacknowledged sets the general call flag in short-address mode; in wide mode it sets the first-byte flag
// - master data byte unacknowledged after acked address, other than a general call, sets data flag
// - second byte of wide address unacknowledged sets second-byte flag
// - first byte of wide address unacknowledged sets first-byte flag
// - short address unacknowledged sets short-address flag
// - slave transmitter changes data as it starts holding clock low, then holds it programmed periods
//
// Strobed register access was left to the implementer.
`include "iafs_consts.vh"
`default_nettype none

module iafs_core (
    input wire clock, // block clock
    input wire rst_n, // async reset, active low
    input wire [31:0] reg_addr, // register address
    input wire [15:0] reg_wdata, // register write data
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    output reg [15:0] reg_rdata, // read data, cycle after strobe
    input wire scl_in, // bus clock pin level
    output wire scl_out, // bus clock drive level
    output wire scl_oe, // bus clock pulled low
    input wire sda_in, // bus data pin level
    output wire sda_out, // bus data drive level
    output reg sda_oe, // bus data pulled low
    input wire slave_tx_active, // servicing a slave read
    input wire slave_tx_load, // pulse: new byte to send
    input wire [7:0] slave_tx_data, // byte to send
    output reg slave_tx_byte_done, // pulse: byte shifted out
    output reg master_abort, // pulse: master transfer aborted
    output wire controller_enable_bit // controller enable level
);

// ----------------------------------------
// address decode helper
// ----------------------------------------
function hit;
    input [31:0] addr;
    input [31:0] target;
    begin
        hit = (addr == target);
    end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] data_setup_delay_value;
reg [2:0] control;
reg [`IAFS_NUM_FLAGS-1:0] transmit_abort_cause;
wire [`IAFS_NUM_FLAGS-1:0] flag_set;
wire flag_clear;
wire wide_mode;
wire master_mode;

assign controller_enable_bit = control[`IAFS_CTRL_ENABLE];
assign wide_mode = control[`IAFS_CTRL_WIDE];
assign master_mode = control[`IAFS_CTRL_MASTER];
assign flag_clear = reg_rd & hit(reg_addr, `IAFS_ADDR_CLEAR);

// software writes; setup delay locked while enabled
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        data_setup_delay_value <= `IAFS_SETUP_RESET;
        control <= 3'h0;
    end
    else if (reg_wr)
    begin
        if (hit(reg_addr, `IAFS_ADDR_SETUP) && !controller_enable_bit)
            data_setup_delay_value <= reg_wdata[7:0];
        if (hit(reg_addr, `IAFS_ADDR_CTRL))
            control <= reg_wdata[2:0];
    end
end

// sticky flags, set wins over clear
genvar gi;
generate
    for (gi = 0; gi < `IAFS_NUM_FLAGS; gi = gi + 1)
    begin : flag_bits
        always @(posedge clock or negedge rst_n)
        begin
            if (!rst_n)
                transmit_abort_cause[gi] <= 1'b0;
            else if (flag_set[gi])
                transmit_abort_cause[gi] <= 1'b1;
            else if (flag_clear)
                transmit_abort_cause[gi] <= 1'b0;
        end
    end
endgenerate

// read data, one cycle after the strobe
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
        reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
        if (hit(reg_addr, `IAFS_ADDR_ABORT))
            reg_rdata <= {11'h000, transmit_abort_cause};
        else if (hit(reg_addr, `IAFS_ADDR_SETUP))
            reg_rdata <= {8'h00, data_setup_delay_value};
        else if (hit(reg_addr, `IAFS_ADDR_CTRL))
            reg_rdata <= {13'h0000, control};
        else
            reg_rdata <= 16'h0000;
    end
    else
        reg_rdata <= 16'h0000;
end

// ----------------------------------------
// pin synchronisers and edge detection
// ----------------------------------------
reg scl_meta;
reg scl_sync;
reg scl_prev;
reg sda_meta;
reg sda_sync;
reg sda_prev;
wire scl_rise;
wire scl_fall;
wire bus_start;
wire bus_stop;

always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        scl_meta <= 1'b1;
        scl_sync <= 1'b1;
        scl_prev <= 1'b1;
        sda_meta <= 1'b1;
        sda_sync <= 1'b1;
        sda_prev <= 1'b1;
    end
    else
    begin
        scl_meta <= scl_in;
        scl_sync <= scl_meta;
        scl_prev <= scl_sync;
        sda_meta <= sda_in;
        sda_sync <= sda_meta;
        sda_prev <= sda_sync;
    end
end

assign scl_rise = scl_sync & ~scl_prev;
assign scl_fall = ~scl_sync & scl_prev;
assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
assign bus_stop = scl_sync & scl_prev & ~sda_prev & sda_sync;

// ----------------------------------------
// master transfer monitor
// ----------------------------------------
localparam [2:0] MON_IDLE = 3'b001;
localparam [2:0] MON_BITS = 3'b010;
localparam [2:0] MON_HALT = 3'b100;

reg [2:0] mon_state;
reg [2:0] next_mon_state;
reg [3:0] bit_count;
reg [1:0] byte_index;
reg [7:0] shift_in;
reg first_is_gcall;
reg ack_slot;
reg nack_seen;
wire any_abort;

// acknowledge slot sampled on the ninth rising edge
always @*
begin
    ack_slot = scl_rise & (bit_count == `IAFS_ACK_SLOT);
    nack_seen = ack_slot & sda_sync & (mon_state == MON_BITS);
end

// classify the unacknowledged byte
assign flag_set[`IAFS_FLAG_SHORT] = nack_seen & !wide_mode & (byte_index == `IAFS_BYTE_FIRST)
    & (shift_in != `IAFS_GCALL_BYTE);
assign flag_set[`IAFS_FLAG_GCALL] = nack_seen & !wide_mode & (byte_index == `IAFS_BYTE_FIRST)
    & (shift_in == `IAFS_GCALL_BYTE);
assign flag_set[`IAFS_FLAG_WIDE1] = nack_seen & wide_mode
    & (byte_index == `IAFS_BYTE_FIRST);
assign flag_set[`IAFS_FLAG_WIDE2] = nack_seen & wide_mode
    & (byte_index == `IAFS_BYTE_SECOND);
assign flag_set[`IAFS_FLAG_DATA] = nack_seen & !first_is_gcall
    & (byte_index == `IAFS_BYTE_LATER || (!wide_mode && byte_index == `IAFS_BYTE_SECOND));
assign any_abort = |flag_set;

// monitor state transitions
always @*
begin
    case (mon_state)
        MON_IDLE:
            next_mon_state = (bus_start && master_mode) ? MON_BITS : MON_IDLE;
        MON_BITS:
            if (bus_stop)
                next_mon_state = MON_IDLE;
            else if (any_abort)
                next_mon_state = MON_HALT;
            else
                next_mon_state = MON_BITS;
        MON_HALT:
            next_mon_state = (bus_stop || bus_start) ? MON_IDLE : MON_HALT;
        default:
            next_mon_state = MON_IDLE;
    endcase
end

// bit and byte counting within a master transfer
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        mon_state <= MON_IDLE;
        bit_count <= 4'h0;
        byte_index <= `IAFS_BYTE_FIRST;
        shift_in <= 8'h00;
        first_is_gcall <= 1'b0;
        master_abort <= 1'b0;
    end
    else
    begin
        mon_state <= next_mon_state;
        master_abort <= any_abort;
        if (bus_start)
        begin
            bit_count <= 4'h0;
            byte_index <= `IAFS_BYTE_FIRST;
            first_is_gcall <= 1'b0;
        end
        else if (scl_rise && mon_state == MON_BITS)
        begin
            if (ack_slot)
            begin
                bit_count <= 4'h0;
                if (byte_index == `IAFS_BYTE_FIRST)
                    first_is_gcall <= !wide_mode && (shift_in == `IAFS_GCALL_BYTE);
                if (byte_index != `IAFS_BYTE_LATER)
                    byte_index <= byte_index + 2'h1;
            end
            else
            begin
                bit_count <= bit_count + 4'h1;
                shift_in <= {shift_in[6:0], sda_sync};
            end
        end
    end
end

// ----------------------------------------
// slave transmitter with data setup delay
// ----------------------------------------
reg [7:0] tx_shift;
reg [3:0] tx_bits;
wire hold_busy;
wire hold_start;

// stretch the clock low on each falling edge while bits remain
assign hold_start = scl_fall & slave_tx_active & (tx_bits <= `IAFS_LAST_BIT);
assign scl_oe = hold_busy | hold_start;
assign scl_out = 1'b0;
assign sda_out = 1'b0;

iafs_delay_timer setup_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(hold_start),
    .load_value(data_setup_delay_value),
    .busy(hold_busy),
    .done()
);

// data changes as the hold begins, so it is set up for the whole delay
always @(posedge clock or negedge rst_n)
begin
    if (!rst_n)
    begin
        tx_shift <= 8'h00;
        tx_bits <= `IAFS_ACK_SLOT;
        sda_oe <= 1'b0;
        slave_tx_byte_done <= 1'b0;
    end
    else
    begin
        slave_tx_byte_done <= 1'b0;
        if (!slave_tx_active)
        begin
            tx_bits <= `IAFS_ACK_SLOT;
            sda_oe <= 1'b0;
        end
        else if (slave_tx_load)
        begin
            tx_shift <= slave_tx_data;
            tx_bits <= 4'h0;
        end
        else if (hold_start)
        begin
            sda_oe <= ~tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
            tx_bits <= tx_bits + 4'h1;
            slave_tx_byte_done <= (tx_bits == `IAFS_LAST_BIT);
        end
        else if (scl_fall && tx_bits == `IAFS_ACK_SLOT)
            sda_oe <= 1'b0; // release for the master's acknowledge
    end
end

endmodule
`default_nettype wire

// ==== bench/iafs_props.sv ====
// concurrent checks on the abort-flag and data-setup block ports
`include "iafs_consts.vh"
`default_nettype none
module iafs_props (
    input wire logic clock, // block clock
    input wire logic rst_n, // async reset, active low
    input wire logic [31:0] reg_addr, // register address
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [15:0] reg_rdata, // read data
    input wire logic scl_in, // bus clock level
    input wire logic scl_oe, // bus clock pulled low
    input wire logic sda_oe, // bus data pulled low
    input wire logic slave_tx_active, // slave read in service
    input wire logic master_abort, // abort pulse
    input wire logic controller_enable_bit // enable level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] setup_model;
    logic [7:0] hold_cnt;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // expected delay value and length of the current clock hold
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            setup_model <= 8'h64;
            hold_cnt <= 8'h00;
        end
        else
        begin
            if (reg_wr && reg_addr == `IAFS_ADDR_SETUP && !controller_enable_bit)
                setup_model <= reg_wdata[7:0];
            hold_cnt <= scl_oe ? hold_cnt + 8'h01 : 8'h00;
        end
    end
    sequence s_setup_rd;
        reg_rd && reg_addr == `IAFS_ADDR_SETUP;
    endsequence
    sequence s_hold_end;
        $fell(scl_oe) && slave_tx_active;
    endsequence
    a_setup_value: assert property (
        s_setup_rd |=> reg_rdata == {8'h00, setup_model}) else $error("setup read wrong");
    a_hold_length: assert property (
        s_hold_end |-> hold_cnt >= setup_model && hold_cnt <= setup_model + 8'h02)
        else $error("clock hold length wrong");
    a_data_in_low: assert property (
        slave_tx_active && $changed(sda_oe) |-> !$past(scl_in)) else $error("data moved high");
    a_hold_cause: assert property (
        $rose(scl_oe) |-> slave_tx_active) else $error("clock held outside slave read");
    a_enable_follow: assert property (
        reg_wr && reg_addr == `IAFS_ADDR_CTRL |=> controller_enable_bit == $past(reg_wdata[0]))
        else $error("enable bit wrong");
    a_abort_pulse: assert property (
        master_abort |=> !master_abort) else $error("abort pulse too long");
    a_flags_only: assert property (
        reg_rd && reg_addr == `IAFS_ADDR_ABORT |=> reg_rdata[15:5] == 11'h000)
        else $error("abort upper bits set");
    a_clear_zero: assert property (
        reg_rd && reg_addr == `IAFS_ADDR_CLEAR |=> reg_rdata == 16'h0000)
        else $error("clear read not zero");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside slot");
endmodule
bind iafs_core iafs_props chk_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe), .slave_tx_active(slave_tx_active),
    .master_abort(master_abort), .controller_enable_bit(controller_enable_bit));
`default_nettype wire

// ==== bench/iafs_peer.sv ====
// remote master and slave on the two-wire bus, behavioural
`default_nettype none
module iafs_peer (
    output var logic scl_low, // pulls bus clock low
    output var logic sda_low, // pulls bus data low
    input wire logic scl, // bus clock line
    input wire logic sda // bus data line
);
    timeunit 1ns;
    timeprecision 1ps;
    // lines released, pull-ups hold them high
    initial
    begin
        scl_low = 0;
        sda_low = 0;
    end
    // one bit; waits while the block holds the clock low
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        #80 scl_low = 0;
        wait (scl === 1'b1);
        #80 r = sda;
        #80 scl_low = 1;
        #80;
    endtask
    task automatic start();
        sda_low = 1;
        #160 scl_low = 1;
        #160;
    endtask
    task automatic stop();
        sda_low = 1;
        #80 scl_low = 0;
        wait (scl === 1'b1);
        #160 sda_low = 0;
        #160;
    endtask
    // byte then answer bit: 0 acknowledged, 1 refused
    task automatic xfer(input logic [8:0] w);
        logic r;
        for (int i = 8; i >= 0; i--)
            bit_io(w[i], r);
    endtask
    // receive a byte, then refuse further data
    task automatic rx(output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++)
        begin
            bit_io(1'b1, r);
            d = {d[6:0], r};
        end
        bit_io(1'b1, r);
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// testbench for the abort-flag and data-setup block
`include "iafs_consts.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, slave_tx_active = 0, slave_tx_load = 0;
    logic [31:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, d;
    logic [7:0] slave_tx_data = 0, rx;
    logic p_scl, p_sda;
    wire [15:0] reg_rdata;
    wire scl_oe, sda_oe, done_p, abort_p, en;
    wire scl = !(scl_oe || p_scl);
    wire sda = !(sda_oe || p_sda);
    int n_fail = 0, check_count = 0, n_abort = 0, n_done = 0, a0;
    logic [15:0] c_ctrl [6] = '{16'h5, 16'h7, 16'h7, 16'h5, 16'h5, 16'h7};
    logic [23:0] c_bytes [6] = '{24'ha0, 24'hf0, 24'hf055, 24'ha012, 24'h00, 24'hf05533};
    int c_n [6] = '{1, 1, 2, 2, 1, 3};
    logic [15:0] c_exp [6] = '{16'h1, 16'h2, 16'h4, 16'h8, 16'h10, 16'h8};
    iafs_core dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .slave_tx_active(slave_tx_active), .slave_tx_load(slave_tx_load),
        .slave_tx_data(slave_tx_data), .slave_tx_byte_done(done_p),
        .master_abort(abort_p), .controller_enable_bit(en));
    iafs_peer peer_u (.scl_low(p_scl), .sda_low(p_sda), .scl(scl), .sda(sda));
    initial
    begin
        forever #20 clock = ~clock;
    end
    // pulse counters
    always @(posedge clock)
    begin
        n_abort += (abort_p === 1'b1);
        n_done += (done_p === 1'b1);
    end
    task automatic wr(input logic [31:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [15:0] v);
        @(posedge clock);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 0;
        @(negedge clock);
        v = reg_rdata;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string n);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (20000) @(posedge clock);
        n_fail++;
        final_report();
    end
    initial
    begin
        repeat (5) @(posedge clock);
        rst_n <= 1;
        rd(`IAFS_ADDR_SETUP, d);
        chk(d, 16'h0064, "setup reset");
        rd(`IAFS_ADDR_ABORT, d);
        chk(d, 16'h0000, "flags reset");
        wr(`IAFS_ADDR_SETUP, 16'h000b);
        rd(`IAFS_ADDR_SETUP, d);
        chk(d, 16'h000b, "setup write");
        wr(`IAFS_ADDR_CTRL, 16'h0005);
        @(negedge clock);
        chk({15'h0000, en}, 16'h0001, "enable bit");
        wr(`IAFS_ADDR_SETUP, 16'h0020);
        rd(`IAFS_ADDR_SETUP, d);
        chk(d, 16'h000b, "setup locked");
        wr(`IAFS_ADDR_ABORT, 16'h001f);
        rd(`IAFS_ADDR_ABORT, d);
        chk(d, 16'h0000, "flags write");
        rd(32'h50001000, d);
        chk(d, 16'h0000, "unmapped");
        $display("test registers done");
        for (int i = 0; i < 6; i++)
        begin
            wr(`IAFS_ADDR_CTRL, c_ctrl[i]);
            rd(`IAFS_ADDR_CLEAR, d);
            rd(`IAFS_ADDR_ABORT, d);
            chk(d, 16'h0000, "flags cleared");
            a0 = n_abort;
            peer_u.start();
            for (int j = c_n[i] - 1; j >= 0; j--)
                peer_u.xfer({c_bytes[i][8*j+:8], j == 0});
            peer_u.stop();
            rd(`IAFS_ADDR_ABORT, d);
            chk(d, c_exp[i], "abort flags");
            chk(16'(n_abort - a0), 16'h0001, "abort pulse");
        end
        $display("test abort flags done");
        wr(`IAFS_ADDR_CTRL, 16'h0000);
        for (int i = 0; i < 2; i++)
        begin
            wr(`IAFS_ADDR_SETUP, i ? 16'h000b : 16'h0002);
            a0 = n_done;
            @(posedge clock);
            slave_tx_active <= 1;
            slave_tx_load <= 1;
            slave_tx_data <= i ? 8'h3c : 8'ha5;
            @(posedge clock);
            slave_tx_load <= 0;
            peer_u.start();
            peer_u.rx(rx);
            peer_u.stop();
            @(posedge clock);
            slave_tx_active <= 0;
            chk({8'h00, rx}, {8'h00, i ? 8'h3c : 8'ha5}, "slave byte");
            chk(16'(n_done - a0), 16'h0001, "byte done");
        end
        $display("test slave delay done");
        final_report();
    end
endmodule
`default_nettype wire
